// File: dv/cfg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
   // pacing clock
   input  wire logic core_clk_i,
   // configuration pins
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      sdi_o,
   output logic      sdo_pin_o,
   input  wire logic sdo_oe_i
);
   logic strap_on;
   logic strap_sdo;
   // open drain: pull-up unless pulled low or strapped
   assign sdo_pin_o = sdo_oe_i ? 1'b0 : (strap_on ? strap_sdo : 1'b1);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
      strap_on = 1'b0;
      strap_sdo = 1'b0;
   end
   // one word, 200 ns serial clock, still between frames
   task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
      int i;
      @(posedge core_clk_i);
      cs_n_o <= 1'b0;
      for (i = 15; i >= 0; i--) begin
         @(posedge core_clk_i);
         sdi_o <= w[i];
         repeat (3) @(posedge core_clk_i);
         sck_o <= 1'b1;
         if (i < 8) rd[i] = sdo_pin_o;
         repeat (4) @(posedge core_clk_i);
         sck_o <= 1'b0;
      end
      repeat (4) @(posedge core_clk_i);
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o; // inverted line, not a stale value
      repeat (8) @(posedge core_clk_i);
   endtask
   // static levels: select, clock, data in, data out
   task automatic strap(input logic [3:0] v);
      cs_n_o <= v[3];
      sck_o <= v[2];
      sdi_o <= v[1];
      strap_sdo <= v[0];
      strap_on <= 1'b1;
   endtask
endmodule
`default_nettype wire

// File: dv/quad_adc_mode_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module quad_adc_mode_ctrl_tb;
   import adc_ctrl_pkg::*;
   logic                   core_clk_i, srst_i, style, cs_n, sck, sdi, sdo_pin, sdo_oe, s_valid, s_ready;
   logic                   bclk, frame, drv_en, term, sleep;
   logic [N_CH*CODE_W-1:0] s_code;
   logic [N_CH-1:0]        lane_a, nap, ch_valid;
   logic [13:0]            ua, code, pat;
   logic [15:0]            w, e;
   logic [7:0]             r, f;
   int                     seed, n_errors, samples_checked, k;

   quad_adc_mode_ctrl #(.WAKE_CYCLES_P(20)) quad_adc_mode_ctrl_i (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .programming_style_select_i(style), .cs_n_i(cs_n),
      .sck_i(sck), .sdi_i(sdi), .sdo_i(sdo_pin), .sdo_o(), .sdo_oe_o(sdo_oe), .sample_valid_i(s_valid),
      .sample_code_i(s_code), .sample_ready_o(s_ready), .lane_a_o(lane_a), .lane_b_o(),
      .output_bit_clock_o(bclk), .frame_marker_o(frame), .output_drive_enable_o(drv_en),
      .termination_enable_o(term), .drive_current_ua_o(ua), .sleep_o(sleep), .nap_channels_o(nap),
      .channel_valid_o(ch_valid));
   cfg_host_model cfg_host_model_i (.core_clk_i(core_clk_i), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
      .sdo_pin_o(sdo_pin), .sdo_oe_i(sdo_oe));

   ////////////////////////////////////////////////////////////
   // expected drive current, doubled with termination
   function automatic logic [13:0] exp_ua(input logic [3:0] d);
      logic [13:0] t[8];
      t = '{14'h0DAC, 14'h0FA0, 14'h1194, 14'h0BB8, 14'h09C4, 14'h0834, 14'h06D6, 14'h06D6};
      return t[d[2:0]] << d[3];
   endfunction
   // expected serial word: coding, then randomizer, pattern wins
   function automatic logic [15:0] exp_word(input logic [13:0] c, input logic [7:0] m, input logic pe);
      logic [13:0] v;
      v = c ^ {m[0], 13'h0000};
      if (m[1]) v = {v[13:1] ^ {13{v[0]}}, v[0]};
      if (pe) v = pat;
      return {v, 2'h0};
   endfunction
   task automatic tick();
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      cfg_host_model_i.xfer({1'b0, a, d}, r);
   endtask
   // payload bits set on purpose, they must be ignored
   task automatic rd(input logic [6:0] a);
      cfg_host_model_i.xfer({1'b1, a, 8'h5A}, r);
   endtask
   // receiver: word starts where the frame marker rises
   task automatic grab(input int n);
      int i;
      w = '0;
      for (i = 0; i < 64 && frame !== 1'b0; i++) tick();
      for (i = 0; i < 64 && frame !== 1'b1; i++) tick();
      for (i = 15; i > 15 - n; i--) begin
         w[i] = lane_a[0];
         tick();
      end
   endtask
   task automatic results();
      if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // 40 MHz core clock
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   // watchdog, between three and four times the expected run
   initial begin
      #1000000;
      n_errors++;
      results();
   end
   // main sequence
   initial begin
      seed = 39;
      srst_i <= 1'b1;
      style <= 1'b0;
      s_valid <= 1'b0;
      s_code <= '0;
      repeat (8) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (4) tick();
      check("drive_ua", ua, 14'h0DAC);
      check("term", term, 1'b0);
      check("sleep", sleep, 1'b0);
      for (k = 0; k < 16; k++) begin
         wr(REG_DRV, {4'h2, k[3:0]});
         check("drive_ua", ua, exp_ua(k[3:0]));
         check("term", term, k[3]);
      end
      for (k = 0; k < 5; k++) begin
         f = 8'($random(seed));
         wr((k < 4) ? 7'(k + 1) : 7'h10, f);
         rd((k < 4) ? 7'(k + 1) : 7'h10);
         check("readback", r, (k < 4) ? f : 8'h00);
         rd((k < 4) ? 7'(k + 1) : 7'h10);
         check("reread", r, (k < 4) ? f : 8'h00);
      end
      wr(REG_DRV, 8'h10);
      s_valid <= 1'b1;
      repeat (40) tick();
      check("drive_en", drv_en, 1'b0);
      check("bit_clock", bclk, 1'b0);
      check("lane_a", lane_a, 4'h0);
      check("fifo_ready", s_ready, 1'b0);
      // coding modes, pattern priority and 12-bit words on lane a
      for (k = 0; k < 6; k++) begin
         code = (k == 0) ? 14'h2000 : (k == 1) ? 14'h3FFF : 14'($random(seed));
         pat = 14'($random(seed));
         f = (k == 4) ? 8'h03 : {6'h00, k[1:0]};
         s_code <= {N_CH{code}};
         wr(REG_FMT_PWR, f);
         wr(REG_PAT_U, {k == 4, 1'b0, pat[13:8]});
         wr(REG_PAT_L, pat[7:0]);
         wr(REG_DRV, (k == 5) ? 8'hA0 : 8'h20);
         repeat (300) tick();
         grab((k == 5) ? 12 : 16);
         e = exp_word(code, f, k == 4);
         check("lane_word", w, (k == 5) ? (e & 16'hFFF0) : e);
      end
      // stop the source so the buffer drains and ready settles high
      s_valid <= 1'b0;
      repeat (300) tick();
      check("fifo_ready", s_ready, 1'b1);
      wr(REG_FMT_PWR, 8'h04);
      check("sleep", sleep, 1'b1);
      check("drive_en", drv_en, 1'b0);
      wr(REG_FMT_PWR, 8'h00);
      check("waking", sleep, 1'b1);
      repeat (30) tick();
      check("awake", sleep, 1'b0);
      wr(REG_FMT_PWR, 8'h50);
      check("nap", nap, 4'h5);
      check("ch_valid", ch_valid, 4'hA);
      wr(REG_FMT_PWR, 8'h00);
      repeat (75) tick();
      check("ch_valid_early", ch_valid, 4'hA);
      repeat (30) tick();
      check("ch_valid", ch_valid, 4'hF);
      style <= 1'b1;
      cfg_host_model_i.strap(4'hF);
      repeat (10) tick();
      check("drive_ua", ua, 14'h0DAC);
      check("term", term, 1'b1);
      check("sleep", sleep, 1'b1);
      cfg_host_model_i.strap(4'h4);
      repeat (40) tick();
      check("drive_ua", ua, 14'h06D6);
      check("term", term, 1'b0);
      check("sleep", sleep, 1'b0);
      results();
   end
endmodule
`default_nettype wire

// File: rtl/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
   // geometry
   localparam int N_CH       = 4;
   localparam int CODE_W     = 14;
   localparam int WORD_W     = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int SPI_BITS   = 16;

   // timing
   localparam int CORE_CLK_HZ     = 40_000_000;
   localparam int SLEEP_WAKE_MS   = 2;
   localparam int WAKE_CYCLES     = SLEEP_WAKE_MS * (CORE_CLK_HZ / 1000);
   localparam int NAP_WAKE_CYCLES = 100;

   // register indices
   localparam logic [6:0] REG_FMT_PWR = 7'h01;
   localparam logic [6:0] REG_DRV     = 7'h02;
   localparam logic [6:0] REG_PAT_U   = 7'h03;
   localparam logic [6:0] REG_PAT_L   = 7'h04;

   // reset values
   localparam logic [7:0] FMT_RST   = 8'h00;
   localparam logic [7:0] DRV_RST   = 8'h00;
   localparam logic [7:0] PAT_U_RST = 8'h00;
   localparam logic [7:0] PAT_L_RST = 8'h00;

   // format and power control fields
   localparam int FMT_TWOS_BIT  = 0;
   localparam int FMT_RAND_BIT  = 1;
   localparam int FMT_SLEEP_BIT = 2;
   localparam int FMT_NAP_LSB   = 4;
   // output driver control fields
   localparam int DRV_CUR_LSB   = 0;
   localparam int DRV_TERM_BIT  = 3;
   localparam int DRV_OFF_BIT   = 4;
   localparam int DRV_LANE1_BIT = 5;
   localparam int DRV_SER_LSB   = 6;
   // pattern fields
   localparam int PAT_EN_BIT    = 7;

   // drive current codes
   localparam logic [2:0] CUR_3500 = 3'h0;
   localparam logic [2:0] CUR_1750 = 3'h6;

   // synchroniser reset, chip select idles high
   localparam logic [4:0] SYNC_RST = 5'h02;

   typedef enum logic [1:0] {
      SER_16 = 2'h0,
      SER_14 = 2'h1,
      SER_12 = 2'h2
   } ser_bits_t;

   // drive current in microamps for each code
   function automatic logic [13:0] cur_ua(input logic [2:0] code);
      case (code)
         3'h0:    cur_ua = 14'h0DAC;
         3'h1:    cur_ua = 14'h0FA0;
         3'h2:    cur_ua = 14'h1194;
         3'h3:    cur_ua = 14'h0BB8;
         3'h4:    cur_ua = 14'h09C4;
         3'h5:    cur_ua = 14'h0834;
         default: cur_ua = 14'h06D6;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: rtl/quad_adc_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module quad_adc_mode_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int WAKE_CYCLES_P = WAKE_CYCLES
) (
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     srst_i,
   // configuration pins
   input  wire logic                     programming_style_select_i,
   input  wire logic                     cs_n_i,
   input  wire logic                     sck_i,
   input  wire logic                     sdi_i,
   input  wire logic                     sdo_i,
   output logic                          sdo_o,
   output logic                          sdo_oe_o,
   // raw offset binary samples from the converter core
   input  wire logic                     sample_valid_i,
   input  wire logic [N_CH*CODE_W-1:0]   sample_code_i,
   output logic                          sample_ready_o,
   // serial output lanes
   output logic [N_CH-1:0]               lane_a_o,
   output logic [N_CH-1:0]               lane_b_o,
   output logic                          output_bit_clock_o,
   output logic                          frame_marker_o,
   // driver and power status
   output logic                          output_drive_enable_o,
   output logic                          termination_enable_o,
   output logic [13:0]                   drive_current_ua_o,
   output logic                          sleep_o,
   output logic [N_CH-1:0]               nap_channels_o,
   output logic [N_CH-1:0]               channel_valid_o
);

   ////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [4:0] sync1;
   logic [4:0] sync2;
   logic       par_mode;
   logic       cs_s;
   logic       sck_s;
   logic       sdi_s;
   logic       sdo_s;
   logic       sck_q;
   logic       sck_rise;
   logic       sck_fall;

   // two flops; only the second stage is read
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sync1 <= SYNC_RST;
         sync2 <= SYNC_RST;
      end else begin
         sync1 <= {sdo_i, sdi_i, sck_i, cs_n_i, programming_style_select_i};
         sync2 <= sync1;
      end
   end

   assign {sdo_s, sdi_s, sck_s, cs_s, par_mode} = sync2;

   // serial clock edge finder
   always_ff @(posedge core_clk_i) begin
      if (srst_i) sck_q <= 1'b0;
      else sck_q <= sck_s;
   end

   assign sck_rise = sck_s & ~sck_q;
   assign sck_fall = ~sck_s & sck_q;

   ////////////////////////////////////////////////////////////////
   // serial configuration port

   logic [4:0]  spi_cnt;
   logic [15:0] spi_shift;
   logic [7:0]  rd_data;
   logic        rd_active;
   logic [15:0] spi_word;
   logic        spi_live;
   logic        wr_strobe;
   logic [7:0]  reg_fmt;
   logic [7:0]  reg_drv;
   logic [7:0]  reg_pu;
   logic [7:0]  reg_pl;

   // strap mode or deselect parks the port
   assign spi_live  = ~par_mode & ~cs_s;
   assign spi_word  = {spi_shift[14:0], sdi_s};
   // write on the sixteenth edge only when the read flag is low
   assign wr_strobe = spi_live & sck_rise & (spi_cnt == 5'(SPI_BITS - 1)) & ~spi_shift[14];

   function automatic logic [7:0] reg_read(input logic [6:0] idx);
      case (idx)
         REG_FMT_PWR: reg_read = reg_fmt;
         REG_DRV:     reg_read = reg_drv;
         REG_PAT_U:   reg_read = reg_pu;
         REG_PAT_L:   reg_read = reg_pl;
         default:     reg_read = 8'h00;
      endcase
   endfunction

   // bit counter, shift-in and readback shifter
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !spi_live) begin
         spi_cnt   <= '0;
         spi_shift <= '0;
         rd_data   <= '0;
         rd_active <= 1'b0;
      end else if (sck_rise && spi_cnt < 5'(SPI_BITS)) begin
         spi_shift <= spi_word;
         spi_cnt   <= spi_cnt + 5'h01;
         // flag and index complete on the eighth edge
         if (spi_cnt == 5'h07 && spi_shift[6]) begin
            rd_data   <= reg_read(spi_word[6:0]);
            rd_active <= 1'b1;
         end
      end else if (sck_fall && rd_active && spi_cnt > 5'h08 && spi_cnt < 5'(SPI_BITS)) begin
         rd_data <= {rd_data[6:0], 1'b0};
      end
   end

   // open drain: only ever pull low, the host pulls up
   assign sdo_o    = 1'b0;
   assign sdo_oe_o = rd_active & ~rd_data[7] & spi_live;

   // configuration registers; reads leave them alone
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         reg_fmt <= FMT_RST;
         reg_drv <= DRV_RST;
         reg_pu  <= PAT_U_RST;
         reg_pl  <= PAT_L_RST;
      end else if (wr_strobe) begin
         case (spi_word[14:8])
            REG_FMT_PWR: reg_fmt <= spi_word[7:0];
            REG_DRV:     reg_drv <= spi_word[7:0];
            REG_PAT_U:   reg_pu  <= spi_word[7:0];
            REG_PAT_L:   reg_pl  <= spi_word[7:0];
            default:     reg_fmt <= reg_fmt;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // effective settings: straps or registers

   logic            eff_twos;
   logic            eff_rand;
   logic            eff_sleep;
   logic [N_CH-1:0] eff_nap;
   logic [2:0]      eff_cur;
   logic            eff_term;
   logic            eff_off;
   logic            one_lane;
   ser_bits_t       ser;
   logic            eff_pat_en;
   logic [13:0]     pat_val;
   logic [13:0]     cur_base;

   // a part-select cannot sit on a call, so the table value gets a name
   assign cur_base = cur_ua(eff_cur);

   // strap mode offers only a subset; the rest stays at defaults
   always_comb begin
      pat_val = {reg_pu[5:0], reg_pl};
      if (par_mode) begin
         eff_twos   = 1'b0;
         eff_rand   = 1'b0;
         eff_nap    = '0;
         eff_off    = 1'b0;
         eff_pat_en = 1'b0;
         one_lane   = cs_s;
         ser        = cs_s ? SER_14 : SER_16;
         eff_cur    = sck_s ? CUR_1750 : CUR_3500;
         eff_term   = sdo_s;
         eff_sleep  = sdi_s;
      end else begin
         eff_twos   = reg_fmt[FMT_TWOS_BIT];
         eff_rand   = reg_fmt[FMT_RAND_BIT];
         eff_nap    = reg_fmt[FMT_NAP_LSB +: N_CH];
         eff_sleep  = reg_fmt[FMT_SLEEP_BIT];
         eff_cur    = reg_drv[DRV_CUR_LSB +: 3];
         eff_term   = reg_drv[DRV_TERM_BIT];
         eff_off    = reg_drv[DRV_OFF_BIT];
         one_lane   = reg_drv[DRV_LANE1_BIT];
         ser        = ser_bits_t'(reg_drv[DRV_SER_LSB +: 2]);
         eff_pat_en = reg_pu[PAT_EN_BIT];
      end
   end

   // termination keeps swing by doubling the current
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         drive_current_ua_o   <= cur_ua(CUR_3500);
         termination_enable_o <= 1'b0;
         nap_channels_o       <= '0;
      end else begin
         drive_current_ua_o   <= eff_term ? {cur_base[12:0], 1'b0} : cur_base;
         termination_enable_o <= eff_term;
         nap_channels_o       <= eff_nap;
      end
   end

   ////////////////////////////////////////////////////////////////
   // sleep and wake sequencing

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_SLEEP = 3'b010,
      ST_WAKE  = 3'b100
   } pwr_state_t;

   pwr_state_t state;
   logic [19:0] wake_cnt;
   logic        running;

   // outputs stay invalid until the reference has recovered
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state    <= ST_RUN;
         wake_cnt <= '0;
      end else begin
         case (state)
            ST_RUN: begin
               if (eff_sleep) state <= ST_SLEEP;
            end
            ST_SLEEP: begin
               wake_cnt <= '0;
               if (!eff_sleep) state <= ST_WAKE;
            end
            ST_WAKE: begin
               wake_cnt <= wake_cnt + 20'h00001;
               if (eff_sleep) state <= ST_SLEEP;
               else if (wake_cnt == 20'(WAKE_CYCLES_P - 1)) state <= ST_RUN;
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   assign running = (state == ST_RUN);

   always_ff @(posedge core_clk_i) begin
      if (srst_i) sleep_o <= 1'b0;
      else sleep_o <= (state != ST_RUN);
   end

   ////////////////////////////////////////////////////////////////
   // sample buffer

   sample_stream_if #(.W(N_CH*CODE_W)) fifo_bus ();

   logic                   load;
   logic [N_CH*CODE_W-1:0] last_code;
   logic [N_CH*CODE_W-1:0] raw_code;
   logic [N_CH*CODE_W-1:0] fmt_code;

   assign fifo_bus.in_valid  = sample_valid_i;
   assign fifo_bus.in_data   = sample_code_i;
   assign fifo_bus.out_ready = load;
   // a sleeping core drains nothing, so the source is stalled
   assign sample_ready_o     = fifo_bus.in_ready;

   sample_fifo #(.W(N_CH*CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .s          (fifo_bus.fifo)
   );

   // an underrun repeats the previous sample rather than glitching
   assign raw_code = fifo_bus.out_valid ? fifo_bus.out_data : last_code;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) last_code <= '0;
      else if (load) last_code <= raw_code;
   end

   ////////////////////////////////////////////////////////////////
   // slot timing, bit clock and frame marker

   logic [4:0] nbits;
   logic [4:0] slot_len;
   logic [4:0] bit_idx;
   logic       word_par;
   logic       out_on;

   // 12-bit mode simply stops before the two lowest bits
   always_comb begin
      case (ser)
         SER_16:  nbits = 5'h10;
         SER_14:  nbits = 5'h0E;
         default: nbits = 5'h0C;
      endcase
   end

   assign slot_len = one_lane ? nbits : {1'b0, nbits[4:1]};
   // disabled outputs stop draining so the source sees back-pressure
   assign load     = out_on & (bit_idx == 5'h00);
   assign out_on   = running & ~eff_off;

   always_ff @(posedge core_clk_i) begin
      if (srst_i || !running) begin
         bit_idx  <= '0;
         word_par <= 1'b0;
      end else begin
         bit_idx <= (bit_idx == slot_len - 5'h01) ? 5'h00 : bit_idx + 5'h01;
         if (load) word_par <= ~word_par;
      end
   end

   // one toggle per bit slot, so data rate is twice the clock
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !out_on) begin
         output_bit_clock_o    <= 1'b0;
         frame_marker_o        <= 1'b0;
         output_drive_enable_o <= 1'b0;
      end else begin
         output_bit_clock_o    <= ~output_bit_clock_o;
         output_drive_enable_o <= 1'b1;
         // two-lane 14-bit frames span two samples
         if (!one_lane && ser == SER_14) frame_marker_o <= load ? ~word_par : frame_marker_o;
         else frame_marker_o <= (bit_idx < {1'b0, slot_len[4:1]});
      end
   end

   ////////////////////////////////////////////////////////////////
   // per-channel formatting, serializing and nap recovery

   for (genvar ch = 0; ch < N_CH; ch++) begin : g_ch
      logic [CODE_W-1:0] raw;
      logic [CODE_W-1:0] code;
      logic [WORD_W-1:0] sh;
      logic [WORD_W-1:0] w;
      logic [6:0]        nap_cnt;

      assign raw = raw_code[ch*CODE_W +: CODE_W];

      // pattern wins, then coding, then randomizer
      always_comb begin
         code = eff_twos ? {~raw[13], raw[12:0]} : raw;
         if (eff_rand) code = {code[13:1] ^ {13{code[0]}}, code[0]};
         if (eff_pat_en) code = pat_val;
      end

      assign fmt_code[ch*CODE_W +: CODE_W] = code;
      assign w = {code, 2'b00};

      // MSB first; two-lane splits odd and even positions
      always_ff @(posedge core_clk_i) begin
         if (srst_i || !out_on) begin
            sh           <= '0;
            lane_a_o[ch] <= 1'b0;
            lane_b_o[ch] <= 1'b0;
         end else if (load) begin
            lane_a_o[ch] <= w[15];
            lane_b_o[ch] <= one_lane ? 1'b0 : w[14];
            sh           <= one_lane ? {w[14:0], 1'b0} : {w[13:0], 2'b00};
         end else begin
            lane_a_o[ch] <= sh[15];
            lane_b_o[ch] <= one_lane ? 1'b0 : sh[14];
            sh           <= one_lane ? {sh[14:0], 1'b0} : {sh[13:0], 2'b00};
         end
      end

      // recovery count restarts whenever the channel naps
      always_ff @(posedge core_clk_i) begin
         if (srst_i) begin
            nap_cnt             <= 7'(NAP_WAKE_CYCLES);
            channel_valid_o[ch] <= 1'b0;
         end else begin
            if (eff_nap[ch]) nap_cnt <= '0;
            else if (nap_cnt != 7'(NAP_WAKE_CYCLES)) nap_cnt <= nap_cnt + 7'h01;
            channel_valid_o[ch] <= running & ~eff_nap[ch] & (nap_cnt == 7'(NAP_WAKE_CYCLES));
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_wr_edge;
      spi_live && sck_rise && spi_cnt == 5'h0F;
   endsequence

   a_reset_defaults: assert property (@(posedge core_clk_i) disable iff (1'b0)
      srst_i |=> reg_fmt == FMT_RST && reg_drv == DRV_RST && reg_pu == PAT_U_RST)
      else $error("configuration not at defaults after reset");

   a_term_double: assert property (
      !par_mode && reg_drv[DRV_TERM_BIT] && reg_drv[2:0] == CUR_1750 ##1 $stable(reg_drv) && !par_mode
      |=> drive_current_ua_o == 14'h0DAC)
      else $error("termination did not double the current");

   a_extra_edges: assert property (
      spi_live && sck_rise && spi_cnt == 5'h10 |=> spi_cnt == 5'h10 && $stable(spi_shift))
      else $error("edge beyond sixteen was sampled");

   a_write_store: assert property (
      s_wr_edge ##0 (!spi_shift[14] && spi_word[14:8] == REG_DRV) |=> reg_drv == $past(spi_word[7:0]))
      else $error("payload not stored");

   a_read_nowrite: assert property (
      s_wr_edge ##0 spi_shift[14] |=> $stable(reg_fmt) && $stable(reg_drv) && $stable(reg_pu))
      else $error("read transfer changed a register");

   a_sdo_owned: assert property (
      sdo_oe_o |-> !sdo_o && !cs_s && !par_mode && spi_cnt >= 5'h08)
      else $error("data out driven outside readback");

   a_pattern_wins: assert property (
      eff_pat_en |-> fmt_code[CODE_W-1:0] == pat_val && fmt_code[N_CH*CODE_W-1 -: CODE_W] == pat_val)
      else $error("pattern not forced");

   a_twos_zero: assert property (
      !eff_pat_en && !eff_rand && eff_twos && raw_code[CODE_W-1:0] == 14'h2000
      |-> fmt_code[CODE_W-1:0] == 14'h0000)
      else $error("mid code not mapped to zero");

   a_out_disable: assert property (
      eff_off && !par_mode |=> !output_drive_enable_o && !output_bit_clock_o && !frame_marker_o && lane_a_o == '0)
      else $error("outputs driven while disabled");

   a_nap_recover: assert property (
      $fell(eff_nap[0]) |-> ##99 !channel_valid_o[0])
      else $error("channel valid too soon after nap");

   a_wake_hold: assert property (
      state == ST_SLEEP ##1 state == ST_WAKE |-> !running [*8])
      else $error("outputs valid right after wakeup");

   a_strap_lanes: assert property (
      par_mode |-> (cs_s ? (one_lane && ser == SER_14) : (!one_lane && ser == SER_16)))
      else $error("strap lane selection wrong");

endmodule
`default_nettype wire

// File: rtl/sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
   parameter int W     = 56,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic      core_clk_i,
   input wire logic      srst_i,
   // stream
   sample_stream_if.fifo s
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0]   count;
   logic          push;
   logic          pop;

   // honest full and empty from the fill count
   assign s.in_ready  = (count != (AW + 1)'(DEPTH));
   assign s.out_valid = (count != '0);
   assign push        = s.in_valid & s.in_ready;
   assign pop         = s.out_valid & s.out_ready;
   assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

   // pointers and fill count
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         rd_ptr <= next_rd_ptr;
         count  <= count + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   // storage, no reset needed
   always_ff @(posedge core_clk_i) begin
      if (push) mem[wr_ptr] <= s.in_data;
   end

   // registered head word; bypass when the new word lands on an empty head
   always_ff @(posedge core_clk_i) begin
      if (srst_i) s.out_data <= '0;
      else if (push && wr_ptr == next_rd_ptr) s.out_data <= s.in_data;
      else s.out_data <= mem[next_rd_ptr];
   end
endmodule
`default_nettype wire

// File: rtl/sample_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sample_stream_if #(parameter int W = 56);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire
